// file: uppf_pkg.sv
`default_nettype none
package uppf_pkg;

  // protection hold time
  localparam int unsigned HOLD_TIME_MS  = 30;
  localparam int unsigned CLK_FREQ_KHZ  = 40000;
  localparam int unsigned HOLD_CYCLES   = HOLD_TIME_MS * CLK_FREQ_KHZ;
  localparam int unsigned SYNC_STAGES   = 2;

  localparam logic       SWITCH_OPEN    = 1'b0;
  localparam logic       FALLBACK_RESET = 1'b0;

  typedef enum logic [1:0] {
    UPPF_POWERUP = 2'b00,
    UPPF_IDLE    = 2'b01,
    UPPF_PROTECT = 2'b10
  } uppf_state_type;

  // comparator results from the connector side, high = outside window
  typedef struct packed {
    logic bus_power_fault;
    logic ground_fault;
    logic dplus_fault;
    logic dminus_fault;
    logic overcurrent;
    logic over_temp;
    logic common_mode_high;
  } uppf_sense_type;

  // pass path switch enables, high = closed
  typedef struct packed {
    logic ground;
    logic bus_power;
    logic dplus;
    logic dminus;
  } uppf_paths_type;

endpackage : uppf_pkg
`default_nettype wire

// file: uppf_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - close four paths only when inputs normal
// - any out-of-window input except common mode opens every path
// - ground sense beyond 50mV is overcurrent
// - paths open while supply absent
// - other faults hold protection at least 30ms
// - bus-power-only fault restarts after 30ms
// - return to idle without external command
// - sample flag pin once for fallback enable
// - ground outside 0.21V means high common mode
// - limit to full speed only when enabled
// - overtemperature opens until cooled by 20C
// - common-mode flag low on high common mode
// - fault flag low on abnormal voltages
module uppf_ctrl #(
  parameter int unsigned HOLD_CYCLES = uppf_pkg::HOLD_CYCLES
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     reset,
  // supply good, high while the device supply is present
  input  wire logic                     supply_good,
  // comparator results, asynchronous
  input  wire uppf_pkg::uppf_sense_type sense,
  // common-mode flag pin, open drain
  input  wire logic                     common_mode_flag_n_in,
  output var  logic                     common_mode_flag_n_out,
  output var  logic                     common_mode_flag_n_oe,
  // fault flag pin, open drain
  output var  logic                     fault_flag_n_out,
  output var  logic                     fault_flag_n_oe,
  // pass path switches and status
  output var  uppf_pkg::uppf_paths_type paths,
  output var  logic                     speed_limit,
  output var  logic                     fallback_enabled
);

  localparam int SENSE_W = $bits(uppf_pkg::uppf_sense_type);
  localparam int CNT_W   = $clog2(HOLD_CYCLES + 1);
  localparam uppf_pkg::uppf_paths_type PATHS_OPEN   = '{default: uppf_pkg::SWITCH_OPEN};
  localparam uppf_pkg::uppf_paths_type PATHS_CLOSED = '{default: ~uppf_pkg::SWITCH_OPEN};

  logic [SENSE_W-1:0]          sense_s1_r;
  logic [SENSE_W-1:0]          sense_s2_r;
  logic                        supply_s1_r;
  logic                        supply_s2_r;
  logic                        flag_s1_r;
  logic                        flag_s2_r;
  uppf_pkg::uppf_sense_type    sense_sync;
  uppf_pkg::uppf_state_type    state_r;
  logic [CNT_W-1:0]            hold_cnt_r;
  logic                        vbus_only_r;
  logic                        any_fault;
  logic                        vbus_only;
  logic                        hold_done;

  // two-stage synchronisers; stage one read only by stage two
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sense_s1_r  <= '0;
      sense_s2_r  <= '0;
      supply_s1_r <= 1'b0;
      supply_s2_r <= 1'b0;
      flag_s1_r   <= 1'b0;
      flag_s2_r   <= 1'b0;
    end else begin
      sense_s1_r  <= sense;
      sense_s2_r  <= sense_s1_r;
      supply_s1_r <= supply_good;
      supply_s2_r <= supply_s1_r;
      flag_s1_r   <= common_mode_flag_n_in;
      flag_s2_r   <= flag_s1_r;
    end
  end

  assign sense_sync = uppf_pkg::uppf_sense_type'(sense_s2_r);
  // thermal comparator carries its own 20C hysteresis
  assign any_fault  = sense_sync.bus_power_fault | sense_sync.ground_fault | sense_sync.dplus_fault
                    | sense_sync.dminus_fault | sense_sync.overcurrent | sense_sync.over_temp;
  assign vbus_only  = sense_sync.bus_power_fault & ~(sense_sync.ground_fault | sense_sync.dplus_fault
                    | sense_sync.dminus_fault | sense_sync.overcurrent | sense_sync.over_temp);
  assign hold_done  = hold_cnt_r >= CNT_W'(HOLD_CYCLES);

  // operating state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_r <= uppf_pkg::UPPF_POWERUP;
    end else if (!supply_s2_r) begin
      state_r <= uppf_pkg::UPPF_POWERUP;
    end else begin
      case (state_r)
        uppf_pkg::UPPF_POWERUP: begin
          state_r <= any_fault ? uppf_pkg::UPPF_PROTECT : uppf_pkg::UPPF_IDLE;
        end
        uppf_pkg::UPPF_IDLE: begin
          if (any_fault) begin
            state_r <= uppf_pkg::UPPF_PROTECT;
          end
        end
        uppf_pkg::UPPF_PROTECT: begin
          // leaves once hold elapsed and inputs are back in window
          if (hold_done && !any_fault) begin
            state_r <= uppf_pkg::UPPF_IDLE;
          end
        end
        default: begin
          state_r <= uppf_pkg::UPPF_POWERUP;
        end
      endcase
    end
  end

  // hold counter, restarted on every faulted cycle unless this protection has seen only bus-power faults
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hold_cnt_r  <= '0;
      vbus_only_r <= 1'b0;
    end else if (state_r != uppf_pkg::UPPF_PROTECT) begin
      hold_cnt_r  <= '0;
      vbus_only_r <= vbus_only;
    end else begin
      vbus_only_r <= vbus_only_r & (vbus_only | ~any_fault);
      if (any_fault && !(vbus_only_r && vbus_only)) begin
        hold_cnt_r <= '0;
      end else if (!hold_done) begin
        hold_cnt_r <= hold_cnt_r + CNT_W'(1);
      end
    end
  end

  // fallback strap caught once on leaving power-up
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fallback_enabled <= uppf_pkg::FALLBACK_RESET;
    end else if (state_r == uppf_pkg::UPPF_POWERUP && supply_s2_r) begin
      fallback_enabled <= flag_s2_r;
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      paths                  <= PATHS_OPEN;
      speed_limit            <= 1'b0;
      common_mode_flag_n_out <= 1'b0;
      common_mode_flag_n_oe  <= 1'b0;
      fault_flag_n_out       <= 1'b0;
      fault_flag_n_oe        <= 1'b0;
    end else begin
      paths <= (state_r == uppf_pkg::UPPF_IDLE && !any_fault && supply_s2_r)
             ? PATHS_CLOSED : PATHS_OPEN;
      speed_limit           <= fallback_enabled & sense_sync.common_mode_high;
      // no drive during power-up so the strap can be read
      common_mode_flag_n_oe <= supply_s2_r && state_r != uppf_pkg::UPPF_POWERUP
                               && sense_sync.common_mode_high;
      fault_flag_n_oe       <= supply_s2_r && (sense_sync.bus_power_fault | sense_sync.ground_fault
                               | sense_sync.dplus_fault | sense_sync.dminus_fault);
    end
  end

  AST_OPEN_ON_FAULT: assert property (@(posedge clk) disable iff (reset)
    any_fault |=> paths == '0) else $error("paths closed during fault");
  AST_OPEN_NO_SUPPLY: assert property (@(posedge clk) disable iff (reset)
    !supply_s2_r |=> paths == '0) else $error("paths closed without supply");
  AST_CLOSE_ALL: assert property (@(posedge clk) disable iff (reset)
    paths != '0 |-> paths == '1) else $error("paths not switched together");
  AST_HOLD_MIN: assert property (@(posedge clk) disable iff (reset)
    $rose(state_r == uppf_pkg::UPPF_PROTECT) |-> hold_cnt_r == '0) else $error("hold count not cleared");
  AST_LEAVE_AFTER_HOLD: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_PROTECT && supply_s2_r && hold_done && !any_fault)
    |=> state_r == uppf_pkg::UPPF_IDLE) else $error("no restart after hold");
  AST_NO_EARLY_EXIT: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_PROTECT && !hold_done) |=> state_r != uppf_pkg::UPPF_IDLE)
    else $error("protection left early");
  AST_STRAP_STABLE: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_IDLE && $past(state_r) == uppf_pkg::UPPF_IDLE)
    |-> $stable(fallback_enabled)) else $error("strap resampled");
  AST_SPEED: assert property (@(posedge clk) disable iff (reset)
    speed_limit |-> $past(fallback_enabled)) else $error("speed limited while disabled");
  AST_FAULT_FLAG: assert property (@(posedge clk) disable iff (reset)
    (supply_s2_r && sense_sync.dplus_fault) |=> fault_flag_n_oe && !fault_flag_n_out)
    else $error("fault flag not driven");
  AST_CM_FLAG: assert property (@(posedge clk) disable iff (reset)
    common_mode_flag_n_oe |-> $past(sense_sync.common_mode_high)) else $error("cm flag without cause");
  AST_CLOSE_IN_IDLE: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_IDLE && !any_fault && supply_s2_r) |=> paths == '1)
    else $error("paths not closed");
  AST_OVERCURRENT: assert property (@(posedge clk) disable iff (reset)
    sense_sync.overcurrent |=> paths == '0) else $error("paths closed on overcurrent");
  AST_NO_SUPPLY_STATE: assert property (@(posedge clk) disable iff (reset)
    !supply_s2_r |=> state_r == uppf_pkg::UPPF_POWERUP) else $error("state kept without supply");
  AST_HOLD_RESTART: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_PROTECT && any_fault && !vbus_only_r) |=> hold_cnt_r == '0)
    else $error("hold count not restarted");
  AST_BUS_ONLY_COUNT: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_PROTECT && vbus_only_r && vbus_only && !hold_done)
    |=> hold_cnt_r == $past(hold_cnt_r) + CNT_W'(1)) else $error("bus power only hold not counting");
  AST_STRAP_CAPTURE: assert property (@(posedge clk) disable iff (reset)
    (state_r == uppf_pkg::UPPF_POWERUP && supply_s2_r) |=> fallback_enabled == $past(flag_s2_r))
    else $error("strap not captured");
  AST_SPEED_SET: assert property (@(posedge clk) disable iff (reset)
    (fallback_enabled && sense_sync.common_mode_high) |=> speed_limit) else $error("speed not limited");
  AST_OVERTEMP: assert property (@(posedge clk) disable iff (reset)
    sense_sync.over_temp |=> paths == '0) else $error("paths closed when hot");
  AST_PIN_LEVELS: assert property (@(posedge clk) disable iff (reset)
    !fault_flag_n_out && !common_mode_flag_n_out) else $error("open drain pin driven high");

  COV_PROTECT: cover property (@(posedge clk) disable iff (reset)
    state_r == uppf_pkg::UPPF_PROTECT ##1 state_r == uppf_pkg::UPPF_IDLE);
  COV_VBUS_ONLY: cover property (@(posedge clk) disable iff (reset)
    vbus_only && state_r == uppf_pkg::UPPF_PROTECT);
  COV_LIMIT: cover property (@(posedge clk) disable iff (reset) speed_limit);
  COV_STRAP_LOW: cover property (@(posedge clk) disable iff (reset)
    state_r == uppf_pkg::UPPF_POWERUP && supply_s2_r && !flag_s2_r);
  COV_OVERCURRENT: cover property (@(posedge clk) disable iff (reset)
    sense_sync.overcurrent && state_r == uppf_pkg::UPPF_PROTECT);

endmodule // uppf_ctrl

`default_nettype wire

// file: uppf_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// board side of the two open-drain flag pins
module uppf_far_model (
  // strap fitted and pin drives from the device
  input  wire logic strap_pullup,
  input  wire logic cm_out,
  input  wire logic cm_oe,
  input  wire logic flt_out,
  input  wire logic flt_oe,
  // resolved pin levels
  output var  logic cm_pin,
  output var  logic flt_pin
);
  // no strap pull-up fitted: the pin sits low, never floats
  assign cm_pin  = cm_oe ? cm_out : strap_pullup;
  assign flt_pin = flt_oe ? flt_out : 1'h1;
endmodule // uppf_far_model
`default_nettype wire

// file: uppf_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module uppf_ctrl_tb;
  // short hold keeps the run small
  localparam int unsigned HOLD = 20;
  logic                     clk = 1'h0, reset = 1'h1, supply_good = 1'h0, strap = 1'h1;
  logic                     cm_pin, flt_pin, cm_out, cm_oe, flt_out, flt_oe, slim, fb;
  uppf_pkg::uppf_sense_type sense = '0;
  uppf_pkg::uppf_paths_type paths;
  int                       fail_count = 0, cmp_count = 0;
  always #12.5 clk = ~clk;
  uppf_ctrl #(.HOLD_CYCLES(HOLD)) uppf_ctrl_i (.clk(clk), .reset(reset), .supply_good(supply_good),
    .sense(sense), .common_mode_flag_n_in(cm_pin), .common_mode_flag_n_out(cm_out),
    .common_mode_flag_n_oe(cm_oe), .fault_flag_n_out(flt_out), .fault_flag_n_oe(flt_oe),
    .paths(paths), .speed_limit(slim), .fallback_enabled(fb));
  uppf_far_model uppf_far_model_i (.strap_pullup(strap), .cm_out(cm_out), .cm_oe(cm_oe),
    .flt_out(flt_out), .flt_oe(flt_oe), .cm_pin(cm_pin), .flt_pin(flt_pin));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // power cycle with strap level pu, then a common-mode episode
  task automatic t_power(input logic pu);
    supply_good = 1'h0;
    strap = pu;
    cyc(4);
    `CHK(paths, 4'h0)
    supply_good = 1'h1;
    cyc(8);
    `CHK(paths, 4'hf)
    `CHK(fb, pu)
    `CHK(flt_pin, 1'h1)
    strap = 1'h1;
    cyc(4);
    `CHK(fb, pu)
    sense.common_mode_high = 1'h1;
    cyc(5);
    `CHK(slim, pu)
    `CHK(cm_pin, 1'h0)
    `CHK(paths, 4'hf)
    sense.common_mode_high = 1'h0;
    cyc(5);
    `CHK(slim, 1'h0)
    `CHK(cm_pin, 1'h1)
    $display("test power strap=%0h done", pu);
  endtask
  // one fault source held for 4 + n cycles, then cleared
  task automatic t_fault(input logic [6:0] m, input logic volt, input logic bus_only, input int n);
    sense = uppf_pkg::uppf_sense_type'(m);
    cyc(4);
    `CHK(paths, 4'h0)
    `CHK(flt_pin, ~volt)
    cyc(n);
    `CHK(paths, 4'h0)
    sense = '0;
    if (bus_only) begin
      // hold already elapsed: reclose right after the clear is synced
      cyc(3);
      `CHK(paths, 4'h0)
      cyc(1);
    end else begin
      // hold counts afresh from the first clean synced cycle
      cyc(HOLD + 3);
      `CHK(paths, 4'h0)
      cyc(1);
    end
    `CHK(paths, 4'hf)
    `CHK(flt_pin, 1'h1)
    $display("test fault %h done", m);
  endtask
  // reset in mid-run: paths open at once, strap caught again
  task automatic t_reset;
    reset = 1'h1;
    cyc(1);
    `CHK(paths, 4'h0)
    `CHK(fb, 1'h0)
    reset = 1'h0;
    cyc(8);
    `CHK(fb, strap)
    `CHK(paths, 4'hf)
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    reset = 1'h0;
    t_power(1'h1);
    t_fault(7'h40, 1'h1, 1'h1, 30);
    t_fault(7'h20, 1'h1, 1'h0, 3);
    t_fault(7'h10, 1'h1, 1'h0, 3);
    t_fault(7'h08, 1'h1, 1'h0, 3);
    t_fault(7'h04, 1'h0, 1'h0, 3);
    t_fault(7'h02, 1'h0, 1'h0, 3);
    t_power(1'h0);
    t_reset();
    print_verdict();
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule // uppf_ctrl_tb
`default_nettype wire
